// >>> hw/sac_defs.vh
// constants for the step attenuator control block
// assumes a 32-bit axi4-lite register port, word-aligned offsets
`ifndef SAC_DEFS_VH
`define SAC_DEFS_VH

// register byte offsets
`define SAC_REG_STATUS     4'h0
`define SAC_REG_FLOAT      4'h4
`define SAC_REG_SERIAL     4'h8
`define SAC_REG_COUNT      4'hC

// status register fields
`define SAC_ST_ATTEN_LSB   0
`define SAC_ST_SERIAL_BIT  8
`define SAC_ST_ADDR_LSB    9
`define SAC_ST_STROBE_BIT  12

// float mask register fields
`define SAC_FL_PAR_LSB     0
`define SAC_FL_ADDR_LSB    8

// serial capture register fields
`define SAC_SR_MATCH_BIT   16

// shift word layout, attenuation word enters first
`define SAC_SHIFT_BITS     16
`define SAC_ADDR_FIELD_LSB 8

// reset values
`define SAC_ATTEN_MAX      8'h7F
`define SAC_FLOAT_RST      11'h000

// axi responses
`define SAC_RESP_OKAY      2'h0
`define SAC_RESP_SLVERR    2'h2

`endif

// >>> hw/sac_pin_sync.v
// three-stage synchroniser for pins from outside the aclk domain
// assumes aclk far faster than any pin change (link clock 80 ns)
`timescale 1ns/100ps
module sac_pin_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             aclk,
  input  wire             aresetn,
  // pin side
  input  wire [WIDTH-1:0] pin_in,
  // aclk side
  output reg  [WIDTH-1:0] level_q
);

  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge aclk) begin
        if (!aresetn) begin
          s1_q[i]    <= 1'b0;
          s2_q[i]    <= 1'b0;
          s3_q[i]    <= 1'b0;
          level_q[i] <= 1'b0;
        end else begin
          s1_q[i] <= pin_in[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
          // a change counts only once stages two and three agree
          if (s2_q[i] == s3_q[i]) begin
            level_q[i] <= s3_q[i];
          end
        end
      end
    end
  endgenerate

endmodule

// >>> hw/sac_top.v
// control-word logic of a 7-bit step attenuator with axi4-lite status
// assumes pins arrive asynchronously; aclk 125 MHz, sync reset
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "sac_defs.vh"

// Functional notes
// - strobe held high in parallel mode: state follows parallel bits
// - strobe low in parallel mode: state holds while bits change
// - strobe pulse high then low captures the parallel word
// - unconnected parallel bits read as logic low
// - unconnected address straps give address zero
// - serial word is 16 bits lsb first, attenuation then address
// - serial word updates state only when address matches straps
// - mode select low picks parallel, high picks serial interface
// - state comes up at maximum attenuation until a word is latched
module sac_top (
  // system
  input  wire        aclk,
  input  wire        aresetn,
  // control pins from the host controller
  input  wire        serial_mode_sel,
  input  wire        word_latch_strobe,
  input  wire        serial_clk,
  input  wire        serial_data,
  input  wire [6:0]  parallel_atten_bits,
  input  wire [2:0]  device_address_straps,
  // attenuation state to the rf switch bank
  output reg  [7:0]  atten_word_q,
  // axi4-lite write address
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  // axi4-lite write data
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  output reg  [1:0]  s_axi_bresp,
  // axi4-lite read address
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  input  wire [31:0] s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  // axi4-lite read data
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp
);

  localparam SHIFT_W = `SAC_SHIFT_BITS;
  localparam ALSB    = `SAC_ADDR_FIELD_LSB;

  // synchronised pin levels
  wire [12:0] pins_raw;
  wire [12:0] pins_q;
  wire        mode_serial;
  wire        strobe_lvl;
  wire        sclk_lvl;
  wire        sdata_lvl;
  wire [6:0]  par_lvl;
  wire [2:0]  strap_lvl;
  wire        serial_mode_sel_q;

  assign pins_raw = {device_address_straps, parallel_atten_bits,
                     serial_data, serial_clk, word_latch_strobe};

  // four flops per pin: none of these pins has any timing tie to aclk
  sac_pin_sync #(
    .WIDTH   (13)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_in  (pins_raw),
    .level_q (pins_q)
  );

  assign strobe_lvl  = pins_q[0];
  assign sclk_lvl    = pins_q[1];
  assign sdata_lvl   = pins_q[2];
  assign par_lvl     = pins_q[9:3];
  assign strap_lvl   = pins_q[12:10];
  assign mode_serial = serial_mode_sel_q;

  // mode select is a pin too; it rides its own synchroniser

  sac_pin_sync #(
    .WIDTH   (1)
  ) u_sync_mode (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_in  (serial_mode_sel),
    .level_q (serial_mode_sel_q)
  );

  // software-held float mask: a set bit marks a pin as unconnected
  reg  [10:0] float_q;
  wire [6:0]  par_eff;
  wire [2:0]  addr_eff;

  // pad pull-down modelled as a forced zero on floated pins
  assign par_eff  = par_lvl &
                    ~float_q[`SAC_FL_PAR_LSB +: 7];
  assign addr_eff = strap_lvl &
                    ~float_q[`SAC_FL_ADDR_LSB +: 3];

  // edge detection on the agreed pin levels
  reg  strobe_prev_q;
  reg  sclk_prev_q;
  wire strobe_rise;
  wire sclk_rise;

  assign strobe_rise = strobe_lvl & ~strobe_prev_q;
  assign sclk_rise   = sclk_lvl & ~sclk_prev_q;

  // serial shift path and capture bookkeeping
  reg  [SHIFT_W-1:0] shift_q;
  reg  [SHIFT_W-1:0] last_word_q;
  reg                last_match_q;
  // counter wraps silently; software reads it twice to see activity
  reg  [15:0]        update_cnt_q;
  wire               addr_match;

  assign addr_match = (shift_q[ALSB +: 3] == addr_eff);

  always @(posedge aclk) begin
    if (!aresetn) begin
      strobe_prev_q <= 1'b0;
      sclk_prev_q   <= 1'b0;
      shift_q       <= {SHIFT_W{1'b0}};
      last_word_q   <= {SHIFT_W{1'b0}};
      last_match_q  <= 1'b0;
      atten_word_q  <= `SAC_ATTEN_MAX;
      update_cnt_q  <= 16'h0000;
    end else begin
      strobe_prev_q <= strobe_lvl;
      sclk_prev_q   <= sclk_lvl;
      if (mode_serial) begin
        // shift only while the strobe is low, so loading never disturbs
        // the attenuation already applied
        if (sclk_rise && !strobe_lvl) begin
          shift_q <= {sdata_lvl, shift_q[SHIFT_W-1:1]};
        end
        // the strobe rising edge latches the word once; host lowers it
        // again before the next word
        if (strobe_rise) begin
          last_word_q  <= shift_q;
          last_match_q <= addr_match;
          if (addr_match) begin
            atten_word_q <= shift_q[7:0];
            update_cnt_q <= update_cnt_q + 16'h0001;
          end
        end
      end else begin
        // strobe high makes the latch transparent; a pulse leaves the
        // last presented word held after its falling edge
        if (strobe_lvl) begin
          // count real changes only, so a held strobe does not run it
          if (atten_word_q != {1'b0, par_eff}) begin
            update_cnt_q <= update_cnt_q + 16'h0001;
          end
          atten_word_q <= {1'b0, par_eff};
        end
      end
    end
  end

  // axi4-lite write side: one write at a time, aw and w in any order
  reg [3:0]  wr_addr_q;
  reg        aw_full_q;
  reg [31:0] wr_data_q;
  reg [3:0]  wr_strb_q;
  reg        w_full_q;
  reg        wr_bad_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SAC_RESP_OKAY;
      wr_addr_q     <= 4'h0;
      aw_full_q     <= 1'b0;
      wr_data_q     <= 32'h00000000;
      wr_strb_q     <= 4'h0;
      w_full_q      <= 1'b0;
      wr_bad_q      <= 1'b0;
      float_q       <= `SAC_FLOAT_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        wr_addr_q     <= s_axi_awaddr[3:0];
        // high bits must not alias onto the mapped offsets
        wr_bad_q      <= |s_axi_awaddr[31:4];
        aw_full_q     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wr_data_q    <= s_axi_wdata;
        wr_strb_q    <= s_axi_wstrb;
        w_full_q     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (aw_full_q && w_full_q && !s_axi_bvalid) begin
        aw_full_q    <= 1'b0;
        w_full_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `SAC_RESP_OKAY;
        case (wr_addr_q)
          `SAC_REG_FLOAT: begin
            if (wr_strb_q[0] && !wr_bad_q) begin
              float_q[6:0] <= wr_data_q[6:0];
            end
            if (wr_strb_q[1] && !wr_bad_q) begin
              float_q[10:8] <= wr_data_q[10:8];
            end
          end
          // read-only registers ignore writes
          `SAC_REG_STATUS,
          `SAC_REG_SERIAL,
          `SAC_REG_COUNT: begin
            s_axi_bresp <= `SAC_RESP_OKAY;
          end
          default: begin
            s_axi_bresp <= `SAC_RESP_SLVERR;
          end
        endcase
        // an aliased address is refused whatever the low bits decode to
        if (wr_bad_q) begin
          s_axi_bresp <= `SAC_RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // axi4-lite read side
  reg [31:0] rd_mux;
  reg        rd_ok;

  always @* begin
    rd_mux = 32'h00000000;
    rd_ok  = 1'b1;
    case (s_axi_araddr[3:0])
      `SAC_REG_STATUS: begin
        rd_mux[`SAC_ST_ATTEN_LSB +: 8] = atten_word_q;
        rd_mux[`SAC_ST_SERIAL_BIT]     = mode_serial;
        rd_mux[`SAC_ST_ADDR_LSB +: 3]  = addr_eff;
        rd_mux[`SAC_ST_STROBE_BIT]     = strobe_lvl;
      end
      `SAC_REG_FLOAT: begin
        rd_mux[10:0] = float_q & 11'h70F | float_q & 11'h07F;
      end
      `SAC_REG_SERIAL: begin
        rd_mux[SHIFT_W-1:0]        = last_word_q;
        rd_mux[`SAC_SR_MATCH_BIT]  = last_match_q;
      end
      `SAC_REG_COUNT: begin
        rd_mux[15:0] = update_cnt_q;
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
    // full decode: aliases of the mapped offsets read as refused
    if (s_axi_araddr[31:4] != 28'h0000000) begin
      rd_mux = 32'h00000000;
      rd_ok  = 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `SAC_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_mux;
        s_axi_rresp   <= rd_ok ? `SAC_RESP_OKAY : `SAC_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

// >>> tb/sac_host.sv
// host controller model driving the attenuator control pins
// assumes the bench sets mode and straps; link clock idles low
`timescale 1ns/100ps
module sac_host (
  // pins to the device
  output logic       serial_mode_sel,
  output logic       word_latch_strobe,
  output logic       serial_clk,
  output logic       serial_data,
  output logic [6:0] parallel_atten_bits,
  output logic [2:0] device_address_straps
);
  initial begin
    {serial_mode_sel, word_latch_strobe, serial_clk, serial_data} = 4'h0;
    parallel_atten_bits = 7'h00;
    device_address_straps = 3'h0;
  end
  // strobe high then low, back low before the next word
  task automatic pulse();
    #97 word_latch_strobe = 1'b1;
    #97 word_latch_strobe = 1'b0;
    // parallel bits stay put for the hold time after the fall
    #100;
  endtask
  task automatic par_word(input logic [6:0] b,
                          input logic direct);
    word_latch_strobe = direct;
    parallel_atten_bits = b;
    #150;
  endtask
  // lsb first, attenuation byte then address byte
  task automatic ser_word(input logic [15:0] w);
    word_latch_strobe = 1'b0;
    #13;
    for (int i = 0; i < 16; i++) begin
      serial_data = w[i];
      #40 serial_clk = 1'b1;
      #40 serial_clk = 1'b0;
    end
    // data no longer held: show the inverse, not the last bit
    serial_data = ~serial_data;
    pulse();
  endtask
endmodule

// >>> tb/sac_top_assertions.sv
// port assertions for the step attenuator control block
// assumes pin changes settle well inside eight aclk cycles
`timescale 1ns/100ps
module sac_top_assertions (
  // system
  input wire logic        aclk,
  input wire logic        aresetn,
  // pins and state
  input wire logic        serial_mode_sel,
  input wire logic        word_latch_strobe,
  input wire logic [6:0]  parallel_atten_bits,
  input wire logic [7:0]  atten_word_q,
  // axi4-lite
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_direct;
    (!serial_mode_sel && word_latch_strobe
      && $stable(parallel_atten_bits))[*8];
  endsequence
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_reset_max: assert property (
    $rose(aresetn) |-> atten_word_q == 8'h7F)
    else $error("state not at maximum after reset");
  // float mask can force zero, which these ports cannot see
  a_direct_follow: assert property (
    s_direct ##0 atten_word_q != 8'h00
    |-> atten_word_q == {1'b0, parallel_atten_bits})
    else $error("direct mode state differs from pins");
  a_strobe_hold: assert property (
    (!word_latch_strobe)[*8] |-> $stable(atten_word_q))
    else $error("state changed with strobe low");
  a_write_resp: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_b_stands: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_r_stands: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr[31:4] != 28'h0
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule
bind sac_top sac_top_assertions sac_top_assertions_inst (
  .aclk, .aresetn, .serial_mode_sel, .word_latch_strobe,
  .parallel_atten_bits, .atten_word_q, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);

// >>> tb/sac_top_bench.sv
// self-checking bench for the step attenuator control block
// assumes the host model drives pins; axi4-lite tasks live here
`timescale 1ns/100ps
module sac_top_bench;
  logic        aclk = 0, aresetn = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rd;
  logic [3:0]  wstrb = 0;
  logic [1:0]  rsp;
  logic [7:0]  exp_a;
  logic [15:0] w;
  wire         awready, wready, bvalid, arready, rvalid;
  wire         mode, strobe, sclk, sdata;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  wire [7:0]   atten;
  wire [6:0]   pbits;
  wire [2:0]   straps;
  int          fail_count = 0, n_checks = 0, seed = 30;
  sac_host sac_host_inst (.serial_mode_sel(mode), .word_latch_strobe(strobe),
    .serial_clk(sclk), .serial_data(sdata), .parallel_atten_bits(pbits),
    .device_address_straps(straps));
  sac_top sac_top_inst (.aclk(aclk), .aresetn(aresetn),
    .serial_mode_sel(mode), .word_latch_strobe(strobe), .serial_clk(sclk),
    .serial_data(sdata), .parallel_atten_bits(pbits),
    .device_address_straps(straps), .atten_word_q(atten),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp));
  initial forever #4 aclk = ~aclk;
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(inout int n);
    n++;
    if (n > 60) begin
      fail_count++;
      end_sim();
    end
  endtask
  // bready raised only once bvalid is seen, so the response must stand
  task automatic wr(input logic [31:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [1:0] r);
    int n = 0;
    bit done = 0;
    @(posedge aclk);
    awvalid <= 1;
    wvalid <= 1;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bready && bvalid) begin
        bready <= 0;
        r = bresp;
        done = 1;
      end else if (bvalid) bready <= 1;
      tick(n);
    end while (!done);
  endtask
  task automatic rd32(input logic [31:0] a, output logic [31:0] d,
                      output logic [1:0] r);
    int n = 0;
    bit done = 0;
    @(posedge aclk);
    arvalid <= 1;
    araddr <= a;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
      if (rready && rvalid) begin
        rready <= 0;
        d = rdata;
        r = rresp;
        done = 1;
      end else if (rvalid) rready <= 1;
      tick(n);
    end while (!done);
  endtask
  function automatic logic [7:0] exp_ser(logic [7:0] old, logic [15:0] v,
                                         logic [2:0] st);
    return (v[10:8] == st) ? v[7:0] : old;
  endfunction
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    repeat (8) @(posedge aclk);
    chk(atten, 8'h7F);
    rd32(32'h0, rd, rsp);
    chk(rd, 32'h7F);
    rd32(32'h10, rd, rsp);
    chk(rsp, 2'h2);
    wr(32'h20, 32'h0, 4'hF, rsp);
    chk(rsp, 2'h2);
    exp_a = 8'h7F;
    repeat (4) begin
      rd = $random(seed);
      sac_host_inst.par_word(rd[6:0], 1'b0);
      @(negedge aclk);
      chk(atten, exp_a);
      sac_host_inst.pulse();
      exp_a = {1'b0, rd[6:0]};
      @(negedge aclk);
      chk(atten, exp_a);
    end
    for (int i = 0; i < 4; i++) begin
      rd = i ? $random(seed) : 32'h7F;
      sac_host_inst.par_word(rd[6:0], 1'b1);
      exp_a = {1'b0, rd[6:0]};
      @(negedge aclk);
      chk(atten, exp_a);
    end
    sac_host_inst.word_latch_strobe = 1'b0;
    #100 sac_host_inst.serial_mode_sel = 1'b1;
    sac_host_inst.device_address_straps = 3'h5;
    for (int i = 0; i < 6; i++) begin
      w = $random(seed);
      if (i % 2) w[10:8] = 3'h5;
      // parallel pins wiggle but must be ignored in serial mode
      sac_host_inst.parallel_atten_bits = w[15:9];
      sac_host_inst.ser_word(w);
      exp_a = exp_ser(exp_a, w, 3'h5);
      @(negedge aclk);
      chk(atten, exp_a);
    end
    wr(32'h4, 32'h77F, 4'h3, rsp);
    rd32(32'h4, rd, rsp);
    chk(rd, 32'h77F);
    sac_host_inst.ser_word(16'h0055);
    @(negedge aclk);
    chk(atten, 8'h55);
    // last latched word with its match flag above it
    rd32(32'h8, rd, rsp);
    chk(rd, 32'h00010055);
    sac_host_inst.serial_mode_sel = 1'b0;
    // mode select settles before the strobe moves
    #100;
    sac_host_inst.par_word(7'h7F, 1'b1);
    @(negedge aclk);
    chk(atten, 8'h00);
    end_sim();
  end
endmodule
